//--- verilog/pecc_params.svh
/*
  Constants of the counter control slice: control field positions, reset
  values, capability offsets and widths.
  Assumes it is included by bare name before any user of these macros.
*/
`ifndef PECC_PARAMS_SVH
`define PECC_PARAMS_SVH

// Control register field positions.
`define PECC_EVCODE_LSB   0
`define PECC_EVCODE_MSB   7
`define PECC_UMASK_LSB    8
`define PECC_UMASK_MSB    15
`define PECC_EDGE_BIT     18
`define PECC_NOTIFY_BIT   20
`define PECC_EN_BIT       22
`define PECC_INV_BIT      23
`define PECC_THR_LSB      24
`define PECC_THR_MSB      31
// Writable control bits; the rest read as zero.
`define PECC_CTL_MASK     32'hffd4ffff
`define PECC_CTL_RESET    32'h00000000

// Data counter.
`define PECC_CTR_W        48
`define PECC_CTR_RESET    48'h000000000000

// Event source shape: events, lanes per event, bits per lane, sum width.
`define PECC_NUM_EV       4
`define PECC_NUM_LANE     8
`define PECC_LANE_W       4
`define PECC_CNT_W        7

// Capability registers in configuration space.
`define PECC_CFG_AW       12
`define PECC_LINK_CAP_OFS 12'h094
`define PECC_SLICE_OFS    12'h09c
`define PECC_LINK_LSB     6
`define PECC_LINK_MSB     7
`define PECC_SLICE_W      28
`define PECC_LINK_CODE_3  2'h2
`define PECC_LINKS_TWO    2'h2
`define PECC_LINKS_THREE  2'h3

`endif

//--- verilog/pecc_pkg.sv
/*
  Types of the counter control slice: unit kinds and address spaces.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pecc_pkg;

  // Kind of owning unit, fixed per instance by a level input.
  typedef enum logic [2:0] {
    PECC_CACHE_AGENT  = 3'h0,
    PECC_IO_UNIT      = 3'h1,
    PECC_IO_COHERENCY = 3'h2,
    PECC_POWER_UNIT   = 3'h3,
    PECC_UTILITY_UNIT = 3'h4,
    PECC_MEMORY_UNIT  = 3'h5,
    PECC_LINK_UNIT    = 3'h6,
    PECC_LINK_BRIDGE  = 3'h7
  } pecc_unit_kind_t;

  // Space through which software reaches this unit's monitor registers.
  typedef enum logic {
    PECC_SPACE_MSR = 1'h0,
    PECC_SPACE_PCI = 1'h1
  } pecc_space_t;

endpackage
`default_nettype wire

//--- verilog/pecc_event_select.sv
/*
  Event selection multiplexer: picks the lanes of the selected event code,
  masks them with the sub-event mask and sums them.
  Assumes lane counts come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pecc_params.svh"
module pecc_event_select (
  input  wire logic [`PECC_NUM_EV*`PECC_NUM_LANE*`PECC_LANE_W-1:0] ev_counts,
  input  wire logic [7:0]             event_code_select,
  input  wire logic [7:0]             sub_event_mask,
  output logic      [`PECC_CNT_W-1:0] sel_count
);

  // Masked count of each lane of the selected event.
  logic [`PECC_LANE_W-1:0] lane_val [`PECC_NUM_LANE];
  // Codes beyond the fitted events select nothing.
  logic                    code_ok;

  assign code_ok = (event_code_select[7:2] == 6'h00);

  // One lane per sub-event; a cleared mask bit removes it from the sum.
  for (genvar i = 0; i < `PECC_NUM_LANE; i++) begin : g_lane
    assign lane_val[i] = (code_ok && sub_event_mask[i]) ?
      ev_counts[({event_code_select[1:0], 5'h00} + i * `PECC_LANE_W)
                +: `PECC_LANE_W] : 4'h0;
  end

  // The sum may exceed one in a cycle, so it is kept at full width.
  always_comb begin
    sel_count = 7'h00;
    for (int j = 0; j < `PECC_NUM_LANE; j++) begin
      sel_count = sel_count + {3'h0, lane_val[j]};
    end
  end

endmodule // pecc_event_select
`default_nettype wire

//--- verilog/pecc_threshold_filter.sv
/*
  Threshold compare with optional inversion and rising-edge detection.
  Assumes the previous compare result is held by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pecc_params.svh"
module pecc_threshold_filter (
  input  wire logic [`PECC_CNT_W-1:0] sel_count,
  input  wire logic [7:0]             threshold,
  input  wire logic                   invert,
  input  wire logic                   edge_detect,
  input  wire logic                   prev_hit,
  output logic                        hit,
  output logic      [`PECC_CNT_W-1:0] increment
);

  // Zero-extended count so the compare sees the full threshold range.
  logic [7:0] count_w;
  logic       thr_on;

  assign count_w = {1'h0, sel_count};
  assign thr_on  = (threshold != 8'h00);

  // Inversion follows the compare; without a threshold any nonzero count is a hit.
  always_comb begin
    if (thr_on) begin
      hit = invert ? (count_w < threshold)
                   : (count_w >= threshold);
    end else begin
      hit = (sel_count != 7'h00);
    end
  end

  // Edge mode counts only a rise; threshold mode counts one per cycle.
  always_comb begin
    if (edge_detect) begin
      increment = {6'h00, hit && !prev_hit};
    end else if (thr_on) begin
      increment = {6'h00, hit};
    end else begin
      increment = sel_count;
    end
  end

endmodule // pecc_threshold_filter
`default_nettype wire

//--- verilog/pecc_counter_slice.sv
/*
  One monitor counter slice: control register, event selection, filter,
  48-bit data counter, unit overflow flag, overflow message, and the two
  capability registers read from configuration space.
  Assumes every input is on clk; the global controller consumes the
  overflow message pulse and drives global enable and freeze.
*/
// What this block does
// - Control register selects event code and sub-events.
// - Sub-event mask combination feeds the selection mux.
// - Counter adds increments larger than one.
// - Nonzero threshold: count at least threshold adds one.
// - Invert makes the test strictly less than.
// - Invert and edge follow compare; software uses threshold one.
// - Edge mode counts only rises from no event.
// - Counting needs global, unit and counter enables.
// - Overflow enable reports overflow to the controller.
// - Read-only 28-bit slice presence vector in 27:0.
// - Link field 7:6 gives two or three links.
// - Memory and link units use PCI space, others MSR.
// - Control field layout is common to both spaces.
// - 48-bit counter overflows from bit 47 and wraps.
// - Overflow sets unit flag; message if enabled.
// - Writing one clears the overflow flag.
`timescale 1ns/100ps
`default_nettype none
`include "pecc_params.svh"
module pecc_counter_slice (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic [`PECC_NUM_EV*`PECC_NUM_LANE*`PECC_LANE_W-1:0] ev_counts,
  input  wire logic                            global_enable,
  input  wire logic                            unit_enable,
  input  wire logic                            global_freeze,
  input  wire logic                            ctl_wr,
  input  wire logic [31:0]                     ctl_wdata,
  input  wire logic                            ctr_wr,
  input  wire logic [`PECC_CTR_W-1:0]          ctr_wdata,
  input  wire logic                            ovf_status_wr,
  input  wire logic                            ovf_status_wdata,
  input  wire pecc_pkg::pecc_unit_kind_t       unit_kind,
  input  wire logic [`PECC_SLICE_W-1:0]        slice_present,
  input  wire logic [1:0]                      link_code,
  input  wire logic                            cfg_rd,
  input  wire logic [`PECC_CFG_AW-1:0]         cfg_addr,
  output logic      [31:0]                     ctl_reg,
  output logic      [`PECC_CTR_W-1:0]          ctr_reg,
  output logic                                 unit_overflow_flag,
  output logic                                 overflow_msg,
  output logic      [31:0]                     cfg_rdata,
  output logic                                 cfg_rvalid,
  output logic      [1:0]                      link_count,
  output pecc_pkg::pecc_space_t                space_reg
);

  // Fields of the control register, one layout for both spaces.
  logic [7:0]             event_code_select;   // Event code.
  logic [7:0]             sub_event_mask;      // Sub-event mask.
  logic                   edge_detect;         // Rising-edge mode.
  logic                   overflow_notify_enable; // Send overflow message.
  logic                   counter_enable;      // Counter-level enable.
  logic                   invert;              // Invert the compare.
  logic [7:0]             threshold;           // Zero disables compare.

  // Datapath between the submodules and the counter.
  logic [`PECC_CNT_W-1:0] sel_count;     // Masked sum of selected lanes.
  logic                   hit;           // Compare result this cycle.
  logic [`PECC_CNT_W-1:0] increment;     // Amount added this cycle.
  logic                   prev_hit_reg;  // Compare result last cycle.
  logic                   count_on;      // All enable levels agree and no freeze.
  logic [`PECC_CTR_W:0]   ctr_sum;       // Counter plus carry out.
  logic                   carry;         // Carry out of bit 47.
  logic [`PECC_CTR_W-1:0] ctr_next;      // Counter next value.
  logic                   ovf_set;       // Overflow event this cycle.
  logic                   ovf_clr;       // Write-one-to-clear request.
  logic [`PECC_SLICE_W-1:0] slice_reg;   // Captured presence vector.
  logic [1:0]             link_code_reg; // Captured link field.
  logic [31:0]            cfg_rdata_next;

  // The same bit positions serve MSR and PCI units alike.
  assign event_code_select      = ctl_reg[`PECC_EVCODE_MSB:`PECC_EVCODE_LSB];
  assign sub_event_mask         = ctl_reg[`PECC_UMASK_MSB:`PECC_UMASK_LSB];
  assign edge_detect            = ctl_reg[`PECC_EDGE_BIT];
  assign overflow_notify_enable = ctl_reg[`PECC_NOTIFY_BIT];
  assign counter_enable         = ctl_reg[`PECC_EN_BIT];
  assign invert                 = ctl_reg[`PECC_INV_BIT];
  assign threshold              = ctl_reg[`PECC_THR_MSB:`PECC_THR_LSB];

  // Control register; bits outside the mask are kept at zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_reg <= `PECC_CTL_RESET;
    end else if (ctl_wr) begin
      ctl_reg <= ctl_wdata & `PECC_CTL_MASK;
    end
  end

  // Selection of the event and its sub-events.
  pecc_event_select u_select (
    .ev_counts         (ev_counts),
    .event_code_select (event_code_select),
    .sub_event_mask    (sub_event_mask),
    .sel_count         (sel_count)
  );

  // Threshold, inversion and edge detection, in that order.
  pecc_threshold_filter u_filter (
    .sel_count   (sel_count),
    .threshold   (threshold),
    .invert      (invert),
    .edge_detect (edge_detect),
    .prev_hit    (prev_hit_reg),
    .hit         (hit),
    .increment   (increment)
  );

  // The edge history tracks every cycle, so re-enabling does not fake a
  // rise from an event that was already present while disabled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_hit_reg <= 1'h0;
    end else begin
      prev_hit_reg <= hit;
    end
  end

  // Counting needs all three levels and no freeze.
  assign count_on = global_enable && unit_enable && counter_enable &&
                    !global_freeze;

  // Full-width add; the carry out of the top bit is the overflow.
  assign ctr_sum = {1'h0, ctr_reg} + {42'h0, increment};
  assign carry   = ctr_sum[`PECC_CTR_W];
  assign ovf_set = count_on && carry && !ctr_wr;

  // A software write takes priority over counting in the same cycle.
  always_comb begin
    if (ctr_wr) begin
      ctr_next = ctr_wdata;
    end else if (count_on) begin
      ctr_next = ctr_sum[`PECC_CTR_W-1:0];
    end else begin
      ctr_next = ctr_reg;
    end
  end

  // Data counter; it wraps and keeps counting until the freeze arrives.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctr_reg <= `PECC_CTR_RESET;
    end else begin
      ctr_reg <= ctr_next;
    end
  end

  // Write one to clear; a new overflow in the same cycle wins.
  assign ovf_clr = ovf_status_wr && ovf_status_wdata;

  // Sticky unit overflow flag.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_overflow_flag <= 1'h0;
    end else if (ovf_set) begin
      unit_overflow_flag <= 1'h1;
    end else if (ovf_clr) begin
      unit_overflow_flag <= 1'h0;
    end
  end

  // One-cycle overflow message to the global controller when enabled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_msg <= 1'h0;
    end else begin
      overflow_msg <= ovf_set && overflow_notify_enable;
    end
  end

  // Capability inputs are captured every cycle; they are static fuses.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slice_reg     <= 28'h0000000;
      link_code_reg <= 2'h0;
    end else begin
      slice_reg     <= slice_present;
      link_code_reg <= link_code;
    end
  end

  // Decoded link count; the undefined code 11 reads as two links.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_count <= `PECC_LINKS_TWO;
    end else if (link_code_reg == `PECC_LINK_CODE_3) begin
      link_count <= `PECC_LINKS_THREE;
    end else begin
      link_count <= `PECC_LINKS_TWO;
    end
  end

  // Read decode of the two read-only capability words.
  always_comb begin
    cfg_rdata_next = 32'h00000000;
    case (cfg_addr)
      `PECC_LINK_CAP_OFS: begin
        cfg_rdata_next[`PECC_LINK_MSB:`PECC_LINK_LSB] = link_code_reg;
      end
      `PECC_SLICE_OFS: begin
        cfg_rdata_next[`PECC_SLICE_W-1:0] = slice_reg;
      end
      default: begin
        cfg_rdata_next = 32'h00000000;
      end
    endcase
  end

  // Read answer one cycle after the request; writes are not accepted.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'h0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= cfg_rdata_next;
      end
    end
  end

  // Address space of this unit's monitor registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      space_reg <= pecc_pkg::PECC_SPACE_MSR;
    end else begin
      case (unit_kind)
        pecc_pkg::PECC_MEMORY_UNIT,
        pecc_pkg::PECC_LINK_UNIT,
        pecc_pkg::PECC_LINK_BRIDGE: begin
          space_reg <= pecc_pkg::PECC_SPACE_PCI;
        end
        default: begin
          space_reg <= pecc_pkg::PECC_SPACE_MSR;
        end
      endcase
    end
  end

  // Checks on the slice behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_HOLD_WHEN_OFF: assert property (
    !count_on && !ctr_wr |=> $stable(ctr_reg))
    else $error("Counter moved while counting was off.");

  AST_THRESH_ONE: assert property (
    count_on && !ctr_wr && threshold != 8'h00 && !edge_detect |=>
    ctr_reg == 48'($past(ctr_reg) + {47'h0, $past(hit)}))
    else $error("Threshold mode did not add exactly the hit.");

  AST_RAW_ADD: assert property (
    count_on && !ctr_wr && threshold == 8'h00 && !edge_detect |=>
    ctr_reg == 48'($past(ctr_reg) + {41'h0, $past(sel_count)}))
    else $error("Raw mode did not add the full count.");

  AST_GE: assert property (
    threshold != 8'h00 && !invert && {1'h0, sel_count} >= threshold |->
    hit)
    else $error("Count at threshold gave no hit.");

  AST_INVERT: assert property (
    threshold != 8'h00 && invert |-> hit == ({1'h0, sel_count} < threshold))
    else $error("Inverted compare is wrong.");

  AST_EDGE: assert property (
    edge_detect && increment != 7'h00 |-> !prev_hit_reg && hit &&
    increment == 7'h01)
    else $error("Edge mode counted without a rise.");

  AST_OVF_SET: assert property (
    ovf_set |=> unit_overflow_flag ##1
    (unit_overflow_flag || $past(ovf_clr)))
    else $error("Overflow did not set the unit flag.");

  AST_OVF_MSG: assert property (
    ovf_set |=> overflow_msg == $past(overflow_notify_enable))
    else $error("Overflow message does not follow its enable.");

  AST_MSG_CAUSE: assert property (
    overflow_msg |-> $past(carry) && $past(count_on))
    else $error("Overflow message without a carry.");

  AST_CLEAR: assert property (
    ovf_clr && !ovf_set |=> !unit_overflow_flag)
    else $error("Write of one did not clear the flag.");

  AST_LINKS: assert property (
    link_code == 2'h2 |=> ##1 link_count == 2'h3)
    else $error("Link code 10 did not give three links.");

  AST_SLICE_READ: assert property (
    cfg_rd && cfg_addr == 12'h09c |=> cfg_rvalid &&
    cfg_rdata == {4'h0, $past(slice_reg)})
    else $error("Slice vector read back wrong.");

endmodule // pecc_counter_slice
`default_nettype wire

//--- tb/pecc_far_side.sv
/*
  Far-side model: event lanes of the owning unit and the global
  controller's freeze reaction to overflow messages.
  Assumes the bench sets its inputs at rising clock edges.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pecc_params.svh"
module pecc_far_side (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] src_event,
  input  wire logic [7:0] lane_mask,
  input  wire logic [3:0] lane_val,
  input  wire logic       overflow_msg,
  input  wire logic       freeze_clr,
  output logic [`PECC_NUM_EV*`PECC_NUM_LANE*`PECC_LANE_W-1:0] ev_counts,
  output logic            global_freeze
);
  // Unselected events carry 3 on every lane, so a wrong pick shows up.
  always_comb begin
    for (int e = 0; e < `PECC_NUM_EV; e++) begin
      for (int l = 0; l < `PECC_NUM_LANE; l++) begin
        if (e == int'(src_event)) begin
          ev_counts[(e*`PECC_NUM_LANE+l)*`PECC_LANE_W +: `PECC_LANE_W] =
            lane_mask[l] ? lane_val : 4'h0;
        end else begin
          ev_counts[(e*`PECC_NUM_LANE+l)*`PECC_LANE_W +: `PECC_LANE_W] =
            4'h3;
        end
      end
    end
  end

  // Freeze follows the first overflow message until software clears it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      global_freeze <= 1'b0;
    end else if (freeze_clr) begin
      global_freeze <= 1'b0;
    end else if (overflow_msg) begin
      global_freeze <= 1'b1;
    end
  end
endmodule  // pecc_far_side
`default_nettype wire

//--- tb/perf_event_counter_control_test.sv
/*
  Self-checking bench of the counter slice: register, config and
  counting scenarios with expected values worked out here.
  Assumes the design and the far-side model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pecc_params.svh"
module perf_event_counter_control_test;
  logic        clk, rst_b, global_enable, unit_enable, ctl_wr, ctr_wr;
  logic        ovf_status_wr, ovf_status_wdata, cfg_rd, freeze_clr;
  logic [31:0] ctl_wdata, ctl_reg, cfg_rdata;
  logic [47:0] ctr_wdata, ctr_reg;
  logic [27:0] slice_present;
  logic [11:0] cfg_addr;
  logic [7:0]  lane_mask;
  logic [3:0]  lane_val;
  logic [1:0]  link_code, link_count, src_event;
  logic        unit_overflow_flag, overflow_msg, cfg_rvalid, global_freeze;
  logic [127:0] ev_counts;
  pecc_pkg::pecc_unit_kind_t unit_kind;
  pecc_pkg::pecc_space_t     space_reg;
  logic [31:0] rd;
  int          err_count, n_tests, msg_cnt, cycles;

  pecc_counter_slice dut (.clk(clk), .rst_b(rst_b), .ev_counts(ev_counts),
    .global_enable(global_enable), .unit_enable(unit_enable),
    .global_freeze(global_freeze), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .ctr_wr(ctr_wr), .ctr_wdata(ctr_wdata), .ovf_status_wr(ovf_status_wr),
    .ovf_status_wdata(ovf_status_wdata), .unit_kind(unit_kind),
    .slice_present(slice_present), .link_code(link_code), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .ctl_reg(ctl_reg), .ctr_reg(ctr_reg),
    .unit_overflow_flag(unit_overflow_flag), .overflow_msg(overflow_msg),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .link_count(link_count), .space_reg(space_reg));

  pecc_far_side far_side (.clk(clk), .rst_b(rst_b), .src_event(src_event),
    .lane_mask(lane_mask), .lane_val(lane_val),
    .overflow_msg(overflow_msg), .freeze_clr(freeze_clr),
    .ev_counts(ev_counts), .global_freeze(global_freeze));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Overflow pulses are counted here, since each stands only one cycle.
  always @(posedge clk) begin
    cycles++;
    if (overflow_msg === 1'b1) begin
      msg_cnt++;
    end
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  // One comparison; unknowns never match.
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr_ctl(input logic [31:0] v);
    @(posedge clk);
    ctl_wr    <= 1'b1;
    ctl_wdata <= v;
    @(posedge clk);
    ctl_wr <= 1'b0;
    #1;
  endtask

  task automatic wr_status(input logic b);
    @(posedge clk);
    ovf_status_wr    <= 1'b1;
    ovf_status_wdata <= b;
    @(posedge clk);
    ovf_status_wr <= 1'b0;
    #1;
  endtask

  // Read pulse, then rvalid must stand exactly one cycle.
  task automatic cfg_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk(48'(cfg_rvalid), 48'h1);
    d = cfg_rdata;
    @(posedge clk);
    #1;
    chk(48'(cfg_rvalid), 48'h0);
  endtask

  // Program, preload, then count over eight edges with a per-cycle lane
  // value. The expected count, flag and messages follow the filter rules;
  // a sent message freezes counting two edges after the wrap.
  task automatic count_run(input logic [31:0] ctl, input logic [7:0] mask,
      input logic [31:0] vals, input logic g, input logic u,
      input logic [47:0] pre);
    logic [47:0] exp;
    logic [48:0] nxt;
    logic [6:0]  s;
    logic [7:0]  thr;
    logic        hit, prev, on, ovf;
    int          f_at, m0;
    exp  = pre;
    ovf  = 1'b0;
    f_at = 99;
    m0   = msg_cnt;
    thr  = ctl[31:24];
    on   = g & u & ctl[`PECC_EN_BIT];
    prev = (thr != 8'h00) & ctl[`PECC_INV_BIT];
    for (int i = 0; i < 8; i++) begin
      // Codes beyond the fitted events must contribute nothing.
      s = (ctl[7:2] == 6'h00) ?
          7'($countones(mask & ctl[15:8]) * vals[4*i +: 4]) : 7'h00;
      if (thr == 8'h00) begin
        hit = (s != 7'h00);
      end else begin
        hit = ctl[`PECC_INV_BIT] ? (8'(s) < thr) : (8'(s) >= thr);
      end
      nxt = {1'b0, exp};
      if (ctl[`PECC_EDGE_BIT]) begin
        nxt = nxt + 49'(hit & !prev);
      end else begin
        nxt = nxt + ((thr == 8'h00) ? 49'(s) : 49'(hit));
      end
      prev = hit;
      if (on && i < f_at) begin
        exp = nxt[47:0];
        if (nxt[48]) begin
          ovf = 1'b1;
          f_at = ctl[`PECC_NOTIFY_BIT] ? i + 2 : 99;
        end
      end
    end
    @(posedge clk);
    ctl_wr           <= 1'b1;
    ctl_wdata        <= ctl;
    ctr_wr           <= 1'b1;
    ctr_wdata        <= pre;
    ovf_status_wr    <= 1'b1;
    ovf_status_wdata <= 1'b1;
    freeze_clr       <= 1'b1;
    src_event        <= ctl[1:0];
    lane_mask        <= mask;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ctl_wr        <= 1'b0;
      ctr_wr        <= 1'b0;
      ovf_status_wr <= 1'b0;
      freeze_clr    <= 1'b0;
      global_enable <= g;
      unit_enable   <= u;
      lane_val      <= vals[4*i +: 4];
    end
    @(posedge clk);
    global_enable <= 1'b0;
    unit_enable   <= 1'b0;
    lane_val      <= 4'h0;
    @(posedge clk);
    #1;
    chk(ctr_reg, exp);
    chk(48'(unit_overflow_flag), 48'(ovf));
    chk(48'(msg_cnt - m0), 48'(ovf & ctl[`PECC_NOTIFY_BIT]));
  endtask

  initial begin
    {rst_b, global_enable, unit_enable, ctl_wr, ctr_wr} = 5'h00;
    {ovf_status_wr, ovf_status_wdata, cfg_rd, freeze_clr} = 4'h0;
    {ctl_wdata, ctr_wdata, cfg_addr, lane_mask, lane_val} = '0;
    {link_code, src_event} = 4'h0;
    slice_present = 28'h0000f0f;
    unit_kind     = pecc_pkg::PECC_CACHE_AGENT;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(48'(ctl_reg), 48'h0);
    chk(ctr_reg, 48'h0);
    chk(48'(link_count), 48'(`PECC_LINKS_TWO));
    $display("test reset done");
    wr_ctl(32'hffffffff);
    chk(48'(ctl_reg), 48'(`PECC_CTL_MASK));
    wr_ctl(32'h00000000);
    $display("test control done");
    cfg_read(`PECC_SLICE_OFS, rd);
    chk(48'(rd), 48'h0000f0f);
    cfg_read(12'h098, rd);
    chk(48'(rd), 48'h0);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      link_code <= 2'(c);
      cfg_read(`PECC_LINK_CAP_OFS, rd);
      chk(48'(rd), 48'(c) << 6);
      chk(48'(link_count), (c == 2) ? 48'h3 : 48'h2);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      unit_kind <= pecc_pkg::pecc_unit_kind_t'(k);
      repeat (2) @(posedge clk);
      #1;
      chk(48'(space_reg), 48'(k >= 5));
    end
    $display("test config done");
    count_run(32'h00400b02, 8'h0f, 32'h12345678, 1, 1, 0);
    count_run(32'h0040ff03, 8'hff, 32'hffffffff, 1, 1, 0);
    count_run(32'h05400101, 8'h01, 32'h05964a27, 1, 1, 0);
    count_run(32'h05c00101, 8'h01, 32'h05964a27, 1, 1, 0);
    count_run(32'h01440101, 8'h01, 32'h22030120, 1, 1, 0);
    count_run(32'h00000101, 8'h01, 32'h11111111, 1, 1, 0);
    count_run(32'h00400101, 8'h01, 32'h11111111, 0, 1, 0);
    count_run(32'h00400101, 8'h01, 32'h11111111, 1, 0, 0);
    count_run(32'h00400104, 8'h01, 32'h11111111, 1, 1, 0);
    $display("test counting done");
    count_run(32'h00400101, 8'h01, 32'h11111111, 1, 1,
      48'hfffffffffffe);
    count_run(32'h00500101, 8'h01, 32'h11111111, 1, 1,
      48'hfffffffffffe);
    wr_status(1'b0);
    chk(48'(unit_overflow_flag), 48'h1);
    wr_status(1'b1);
    chk(48'(unit_overflow_flag), 48'h0);
    $display("test overflow done");
    print_verdict();
  end
endmodule  // perf_event_counter_control_test
`default_nettype wire
